// [mmsd_top.v]
// Purpose: memory mode straps, overlay decode, wait states and combined select
// Assumes: single clock; reset is synchronous active high, straps are pins
// Notes: boot engines live elsewhere; this block only steers and gates them
`timescale 1ns/1ps
`default_nettype none
`include "mmsd_regs.vh"

module mmsd_top #(
  parameter PROG_W = 24,
  parameter DATA_W = 16,
  parameter BOOT_WORDS = 32
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // mode strap pins, asynchronous to clk
  input wire strap_autoboot,
  input wire strap_boot_src,
  // shared flag pin, memory strap during reset
  input wire shared_flag_pin_in,
  output wire shared_flag_pin_out,
  output wire shared_flag_pin_oe,
  // programmable flag from the core
  input wire flag_out_value,
  input wire flag_dir_out,
  output wire flag_in_value,
  // configuration, held by software elsewhere
  input wire [1:0] program_overlay_select,
  input wire [1:0] data_overlay_select,
  input wire [`MMSD_WAIT_W-1:0] data_ext_wait_count,
  input wire [4*`MMSD_WAIT_W-1:0] io_region_wait_counts,
  input wire [3:0] combined_select_enables_wr,
  input wire combined_select_enables_we,
  // core access request
  input wire acc_req,
  input wire acc_is_prog,
  input wire acc_is_io,
  input wire acc_io_instr,
  input wire [13:0] acc_addr,
  output wire acc_ready,
  output wire acc_ext,
  output wire acc_is_ctrl_reg,
  output wire acc_fetch_refused,
  // boot engine status
  input wire byte_dma_word_done,
  input wire host_internal_dma_port_pm0_wr,
  // individual selects, active low; bus grant active high
  input wire byte_select_n,
  input wire bus_granted,
  output wire program_select_n,
  output wire data_select_n,
  output wire io_select_n,
  output wire combined_select_n,
  // external address lines
  output reg [13:0] ext_addr,
  // mode status and select enables
  output wire host_mode,
  output wire boot_byte_dma,
  output wire boot_host_port,
  output wire run_enable,
  output wire [3:0] combined_select_enables
);
  // ****************************************
  // local states
  // ****************************************
  localparam [1:0] ST_RESET = 2'h0;
  localparam [1:0] ST_BOOT = 2'h1;
  localparam [1:0] ST_RUN = 2'h2;

  // region index from io address
  function [1:0] io_region;
    input [`MMSD_IO_ADDR_W-1:0] a;
    begin
      io_region = a[`MMSD_IO_ADDR_W-1:`MMSD_IO_REGION_LSB];
    end
  endfunction

  // ****************************************
  // strap synchronisers and latch
  // ****************************************
  reg [2:0] strap_s1_ff;
  reg [2:0] strap_s2_ff;
  reg memcfg_ff;
  reg autoboot_ff;
  reg bootsrc_ff;
  reg reset_seen_ff;

  always @(posedge clk) begin
    strap_s1_ff <= {shared_flag_pin_in, strap_autoboot, strap_boot_src};
    strap_s2_ff <= strap_s1_ff;
  end

  always @(posedge clk) begin
    if (reset) begin
      // keep tracking while reset holds; last value wins at release
      memcfg_ff <= strap_s2_ff[2];
      autoboot_ff <= strap_s2_ff[1];
      bootsrc_ff <= strap_s2_ff[0];
      reset_seen_ff <= 1'b1;
    end else begin
      // no update outside reset, whatever the flag pin does
      reset_seen_ff <= 1'b0;
    end
  end

  assign host_mode = (memcfg_ff == `MMSD_MEMCFG_HOST);
  wire boot_on = (autoboot_ff == `MMSD_AUTOBOOT_ON);
  assign boot_byte_dma = boot_on && (bootsrc_ff == `MMSD_BOOTSRC_BYTE);
  assign boot_host_port = boot_on && (bootsrc_ff == `MMSD_BOOTSRC_HOST);

  // ****************************************
  // shared flag pin
  // ****************************************
  // pin is never driven in reset so an external strap driver can own it
  assign shared_flag_pin_oe = ~reset & flag_dir_out;
  assign shared_flag_pin_out = flag_out_value;
  assign flag_in_value = strap_s2_ff[2];

  // ****************************************
  // boot hold-off
  // ****************************************
  reg [1:0] boot_st_ff;
  reg [1:0] nxt_boot_st;
  reg [`MMSD_BOOT_CNT_W-1:0] boot_cnt_ff;
  reg [`MMSD_BOOT_CNT_W-1:0] nxt_boot_cnt;
  reg start_ext_ff;

  always @* begin
    nxt_boot_st = boot_st_ff;
    nxt_boot_cnt = boot_cnt_ff;
    case (boot_st_ff)
      ST_RESET: begin
        nxt_boot_cnt = {`MMSD_BOOT_CNT_W{1'b0}};
        if (boot_byte_dma || boot_host_port) begin
          nxt_boot_st = ST_BOOT;
        end else begin
          nxt_boot_st = ST_RUN;
        end
      end
      ST_BOOT: begin
        if (boot_byte_dma) begin
          if (byte_dma_word_done) begin
            nxt_boot_cnt = boot_cnt_ff + {{(`MMSD_BOOT_CNT_W-1){1'b0}}, 1'b1};
          end
          // hold until the last of the boot words lands
          if (byte_dma_word_done &&
              boot_cnt_ff == BOOT_WORDS[`MMSD_BOOT_CNT_W-1:0] - 6'h01) begin
            nxt_boot_st = ST_RUN;
          end
        end else if (host_internal_dma_port_pm0_wr) begin
          nxt_boot_st = ST_RUN;
        end
      end
      ST_RUN: begin
        nxt_boot_st = ST_RUN;
      end
      default: begin
        nxt_boot_st = ST_RESET;
      end
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      boot_st_ff <= ST_RESET;
      boot_cnt_ff <= {`MMSD_BOOT_CNT_W{1'b0}};
      start_ext_ff <= 1'b0;
    end else begin
      boot_st_ff <= nxt_boot_st;
      boot_cnt_ff <= nxt_boot_cnt;
      if (boot_st_ff == ST_RESET) begin
        // no-boot full mode fetches first word from external location 0
        start_ext_ff <= !boot_on && !host_mode;
      end
    end
  end

  assign run_enable = (boot_st_ff == ST_RUN) && !reset_seen_ff;

  // ****************************************
  // address decode
  // ****************************************
  wire [1:0] ovl_sel = acc_is_prog ? program_overlay_select : data_overlay_select;
  wire ovl_hit;
  wire ovl_bank;
  wire [`MMSD_OVL_LOW_W-1:0] ovl_low;
  wire ovl_a0;

  mmsd_overlay_map u_ovl (
    .overlay_sel(ovl_sel),
    .addr(acc_addr),
    .host_mode(host_mode),
    .ext_hit(ovl_hit),
    .bank_bit(ovl_bank),
    .low_addr(ovl_low),
    .lowest_line(ovl_a0)
  );

  // external program execution needs the 24-bit path; host mode is 16 only
  wire prog_ext_allowed = !host_mode && (PROG_W > DATA_W);
  // io space only through the io instructions
  wire io_ok = acc_is_io && acc_io_instr;
  wire prog_ext = acc_is_prog && (ovl_hit || start_ext_ff) && prog_ext_allowed;
  wire data_ext = !acc_is_prog && !acc_is_io && ovl_hit;
  assign acc_fetch_refused = acc_req && acc_is_prog && ovl_hit && !prog_ext_allowed;
  assign acc_ext = prog_ext | data_ext | io_ok;
  assign acc_is_ctrl_reg = !acc_is_prog && !acc_is_io && !ovl_hit &&
                           (acc_addr >= `MMSD_DM_REG_BASE);

  wire [1:0] region = io_region(acc_addr[`MMSD_IO_ADDR_W-1:0]);
  wire [`MMSD_WAIT_W-1:0] io_waits =
    io_region_wait_counts[region*`MMSD_WAIT_W +: `MMSD_WAIT_W];

  // ****************************************
  // wait states
  // ****************************************
  reg [`MMSD_WAIT_W-1:0] nxt_waits;

  always @* begin
    if (io_ok) begin
      nxt_waits = io_waits;
    end else begin
      nxt_waits = data_ext_wait_count;
    end
  end

  wire go = run_enable && acc_req && acc_ext;
  wire wg_busy;
  wire wg_done;

  mmsd_wait_gen u_wait (
    .clk(clk),
    .reset(reset),
    .start(go),
    .waits(nxt_waits),
    .busy(wg_busy),
    .done(wg_done)
  );

  // internal accesses never stall once run_enable is up
  assign acc_ready = run_enable && (!acc_ext || wg_done);

  always @(posedge clk) begin
    if (reset) begin
      ext_addr <= 14'h0000;
    end else if (go && !wg_busy) begin
      ext_addr <= ext_addr;
    end else if (go) begin
      if (io_ok) begin
        // upper three lines left as they were; only eleven are meaningful
        ext_addr <= {ext_addr[13:`MMSD_IO_ADDR_W],
                     acc_addr[`MMSD_IO_ADDR_W-1:0]};
      end else if (host_mode) begin
        ext_addr <= {13'h0000, ovl_a0};
      end else begin
        ext_addr <= {ovl_bank, ovl_low};
      end
    end
  end

  // ****************************************
  // selects
  // ****************************************
  reg [3:0] csel_en_ff;

  always @(posedge clk) begin
    if (reset) begin
      csel_en_ff <= `MMSD_CSEL_RESET;
    end else if (combined_select_enables_we) begin
      csel_en_ff <= combined_select_enables_wr;
    end
  end

  assign combined_select_enables = csel_en_ff;

  wire sel_active = go && wg_busy && !bus_granted;
  assign program_select_n = ~(sel_active && prog_ext);
  assign data_select_n = ~(sel_active && data_ext);
  assign io_select_n = ~(sel_active && io_ok);

  // same gating as the selects themselves so timing matches exactly
  assign combined_select_n = bus_granted | ~(
    (csel_en_ff[`MMSD_CSEL_PMS] & ~program_select_n) |
    (csel_en_ff[`MMSD_CSEL_DMS] & ~data_select_n) |
    (csel_en_ff[`MMSD_CSEL_BMS] & ~byte_select_n) |
    (csel_en_ff[`MMSD_CSEL_IO_SELECT] & ~io_select_n));
endmodule
`default_nettype wire

// [mmsd_regs.vh]
// Purpose: constants for the memory mode and select decode block
// Assumes: included by every design file of the block
// Notes: encodings, widths, addresses and counts only; no logic here
`ifndef MMSD_REGS_VH
`define MMSD_REGS_VH

// strap encodings
`define MMSD_MEMCFG_FULL 1'h0
`define MMSD_MEMCFG_HOST 1'h1
`define MMSD_AUTOBOOT_ON 1'h0
`define MMSD_BOOTSRC_BYTE 1'h0
`define MMSD_BOOTSRC_HOST 1'h1

// boot figures
`define MMSD_BOOT_WORDS 6'h20
`define MMSD_BOOT_CNT_W 6

// overlay decode
`define MMSD_OVL_INTERNAL 2'h0
`define MMSD_OVL_EXT1 2'h1
`define MMSD_OVL_EXT2 2'h2
`define MMSD_OVL_BASE 14'h2000
`define MMSD_OVL_TOP 14'h3fff
`define MMSD_OVL_LOW_W 13

// data memory map
`define MMSD_DM_REG_BASE 14'h3fe0

// io space
`define MMSD_IO_ADDR_W 11
`define MMSD_IO_REGION_LSB 9
`define MMSD_WAIT_W 3

// combined select enable bits: pms, dms, bms, io_select
`define MMSD_CSEL_PMS 0
`define MMSD_CSEL_DMS 1
`define MMSD_CSEL_BMS 2
`define MMSD_CSEL_IO_SELECT 3
`define MMSD_CSEL_RESET 4'hb

`endif

// [mmsd_wait_gen.v]
// Purpose: wait-state counter for one external access
// Assumes: start is held from the same clock until done is seen
// Notes: ready pulses one clock after the loaded count of wait cycles
`timescale 1ns/1ps
`default_nettype none
`include "mmsd_regs.vh"

module mmsd_wait_gen (
  // clock and reset
  input wire clk,
  input wire reset,
  // request
  input wire start,
  input wire [`MMSD_WAIT_W-1:0] waits,
  // answer
  output wire busy,
  output wire done
);
  reg [`MMSD_WAIT_W-1:0] cnt_ff;
  reg run_ff;
  reg done_ff;

  always @(posedge clk) begin
    if (reset) begin
      cnt_ff <= {`MMSD_WAIT_W{1'b0}};
      run_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      // no restart in the answer cycle, while the request is still held
      if (start && !run_ff && !done_ff) begin
        // zero waits completes on the next edge
        if (waits == {`MMSD_WAIT_W{1'b0}}) begin
          done_ff <= 1'b1;
        end else begin
          cnt_ff <= waits;
          run_ff <= 1'b1;
        end
      end else if (run_ff) begin
        if (cnt_ff == {{(`MMSD_WAIT_W-1){1'b0}}, 1'b1}) begin
          run_ff <= 1'b0;
          done_ff <= 1'b1;
        end
        cnt_ff <= cnt_ff - {{(`MMSD_WAIT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign busy = run_ff | (start & ~done_ff);
  assign done = done_ff;
endmodule
`default_nettype wire

// [mmsd_overlay_map.v]
// Purpose: map an overlay field and address onto external overlay lines
// Assumes: purely combinational, same clock domain as its user
// Notes: host mode clears the bank bit and narrows the address to the lowest address line
`timescale 1ns/1ps
`default_nettype none
`include "mmsd_regs.vh"

module mmsd_overlay_map (
  // request
  input wire [1:0] overlay_sel,
  input wire [13:0] addr,
  input wire host_mode,
  // answer
  output reg ext_hit,
  output reg bank_bit,
  output reg [`MMSD_OVL_LOW_W-1:0] low_addr,
  output reg lowest_line
);
  reg in_window;

  always @* begin
    in_window = (addr >= `MMSD_OVL_BASE) && (addr <= `MMSD_OVL_TOP);
    ext_hit = 1'b0;
    bank_bit = 1'b0;
    low_addr = {`MMSD_OVL_LOW_W{1'b0}};
    lowest_line = addr[0];
    if (in_window) begin
      case (overlay_sel)
        `MMSD_OVL_EXT1: begin
          ext_hit = 1'b1;
          bank_bit = 1'b0;
        end
        `MMSD_OVL_EXT2: begin
          ext_hit = 1'b1;
          bank_bit = 1'b1;
        end
        default: begin
          ext_hit = 1'b0;
        end
      endcase
      // only the low 13 bits leave the part; host mode keeps just one line
      if (host_mode) begin
        low_addr = {{(`MMSD_OVL_LOW_W-1){1'b0}}, addr[0]};
        bank_bit = 1'b0;
      end else begin
        low_addr = addr[`MMSD_OVL_LOW_W-1:0];
      end
    end
  end
endmodule
`default_nettype wire

// [mmsd_top_asserts.sv]
// Purpose: port-level checker for the memory mode and select decode block
// Assumes: one clock, synchronous active-high reset
// Notes: external access timing is judged for data and io requests only
`timescale 1ns/1ps
`default_nettype none
module mmsd_chk (
  // clock and reset
  input wire clk,
  input wire reset,
  // access request
  input wire acc_req,
  input wire acc_is_prog,
  input wire acc_is_io,
  input wire [13:0] acc_addr,
  input wire acc_ready,
  input wire acc_ext,
  input wire acc_is_ctrl_reg,
  input wire run_enable,
  input wire [2:0] data_ext_wait_count,
  input wire [11:0] io_region_wait_counts,
  // selects
  input wire byte_select_n,
  input wire bus_granted,
  input wire program_select_n,
  input wire data_select_n,
  input wire io_select_n,
  input wire combined_select_n,
  input wire [3:0] combined_select_enables,
  // mode and flag pin
  input wire host_mode,
  input wire boot_byte_dma,
  input wire flag_dir_out,
  input wire shared_flag_pin_oe
);
  logic [3:0] wt_ff;
  logic [2:0] exp_w;
  // cycles since the request rose; bench drops the request between accesses
  assign exp_w = acc_is_io ? io_region_wait_counts[3*acc_addr[10:9] +: 3] : data_ext_wait_count;
  always @(posedge clk) begin
    if (reset || !acc_req || acc_ready) wt_ff <= 4'h0;
    else wt_ff <= wt_ff + 4'h1;
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  // ****************
  // rules
  // ****************
  csel_reset_a: assert property ($past(reset) |-> combined_select_enables == 4'hb)
    else $error("select enables wrong after reset");
  comb_sel_a: assert property (combined_select_n ==
    !(!bus_granted && |(combined_select_enables
    & ~{io_select_n, byte_select_n, data_select_n, program_select_n})))
    else $error("combined select mismatch");
  flag_free_a: assert property (shared_flag_pin_oe == flag_dir_out)
    else $error("flag pin drive wrong");
  ctrl_reg_a: assert property (acc_req && !acc_is_prog && !acc_is_io && !acc_ext
    |-> acc_is_ctrl_reg == (acc_addr >= 14'h3fe0))
    else $error("control register decode wrong");
  hold_off_a: assert property (!run_enable |-> !acc_ready)
    else $error("access answered while held off");
  int_fast_a: assert property (run_enable && acc_req && !acc_ext |-> acc_ready)
    else $error("internal access not single cycle");
  ext_wait_a: assert property (acc_ready && acc_ext
    && !acc_is_prog |-> wt_ff == {1'b0, exp_w} + 4'h1)
    else $error("wait state count wrong");
  strap_hold_a: assert property (!$past(reset)
    |-> $stable(host_mode) && $stable(boot_byte_dma))
    else $error("strap mode changed after reset");
  io_wait_c: cover property (acc_ready && acc_ext && acc_is_io);
  comb_sel_c: cover property (!combined_select_n);
  run_c: cover property ($rose(run_enable));
endmodule
bind mmsd_top mmsd_chk u_chk (.*);
`default_nettype wire

// [mmsd_far_model.sv]
// Purpose: boot sources and strap driver on the far side of the block
// Assumes: same clock as the block
// Notes: byte boot sends 32 words, host boot one location 0 write
`timescale 1ns/1ps
`default_nettype none
module mmsd_far_model (
  // clock and reset
  input wire clk,
  input wire reset,
  // strap level and block drive
  input wire strap_mem,
  input wire shared_flag_pin_out,
  input wire shared_flag_pin_oe,
  input wire boot_byte_dma,
  input wire boot_host_port,
  // towards the block
  output logic shared_flag_pin_in,
  output logic byte_dma_word_done,
  output logic host_internal_dma_port_pm0_wr,
  output logic [6:0] words_ff,
  output logic pm0_done_ff
);
  logic tog_ff;
  // driver lets go after reset; no pull, so the floating pin wanders
  assign shared_flag_pin_in = shared_flag_pin_oe ? shared_flag_pin_out :
    reset ? strap_mem : ~strap_mem ^ tog_ff;
  always @(posedge clk) begin
    if (reset) begin
      {tog_ff, words_ff, pm0_done_ff, byte_dma_word_done, host_internal_dma_port_pm0_wr} <= '0;
    end else begin
      tog_ff <= ~tog_ff;
      byte_dma_word_done <= boot_byte_dma && tog_ff && words_ff < 7'h20;
      words_ff <= words_ff + {6'h0, byte_dma_word_done};
      host_internal_dma_port_pm0_wr <= boot_host_port && tog_ff && !pm0_done_ff;
      pm0_done_ff <= pm0_done_ff | host_internal_dma_port_pm0_wr;
    end
  end
endmodule
`default_nettype wire

// [testbench.sv]
// Purpose: self-checking bench for the memory mode and select decode block
// Assumes: inputs change on the falling clock edge
// Notes: four of the eight strap settings are booted, then random accesses follow
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, reset, strap_autoboot, strap_boot_src, strap_mem, flag_out_value, flag_dir_out;
  logic combined_select_enables_we, bus_granted, byte_select_n;
  logic acc_req, acc_is_prog, acc_is_io, acc_io_instr;
  logic [1:0] program_overlay_select, data_overlay_select;
  logic [2:0] data_ext_wait_count;
  logic [11:0] io_region_wait_counts;
  logic [3:0] combined_select_enables_wr;
  logic [13:0] acc_addr;
  wire shared_flag_pin_in, shared_flag_pin_out, shared_flag_pin_oe, flag_in_value;
  wire acc_ready, acc_ext, acc_is_ctrl_reg, acc_fetch_refused, byte_dma_word_done;
  wire host_internal_dma_port_pm0_wr, program_select_n, data_select_n, io_select_n;
  wire combined_select_n, host_mode, boot_byte_dma, boot_host_port, run_enable, pm0_done_ff;
  wire [13:0] ext_addr;
  wire [3:0] combined_select_enables;
  wire [6:0] words_ff;
  logic [2:0] cfgs [4] = '{3'h0, 3'h2, 3'h4, 3'h5};
  logic [31:0] r;
  int n_fail, num_checks, seed, i, k;
  mmsd_top dut (.*);
  mmsd_far_model far (.*);
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****************
  // one access, request held until ready is taken
  // ****************
  task automatic acc(input logic p, input logic io, input logic [13:0] a);
    int n;
    logic x;
    logic [15:0] e;
    x = io || (!p && data_overlay_select != 2'h0 && a >= 14'h2000);
    e = io ? {5'h0, a[10:0]} : host_mode ? {15'h0, a[0]} :
      {2'h0, data_overlay_select == 2'h2, a[12:0]};
    acc_is_prog = p;
    acc_is_io = io;
    acc_io_instr = io;
    acc_addr = a;
    acc_req = 1'h1;
    n = 0;
    #1;
    chk("select", !x, p ? program_select_n : io ? io_select_n : data_select_n);
    chk("combined_acc", !x, combined_select_n);
    while (acc_ready !== 1'h1 && n < 20) begin
      @(negedge clk);
      #1;
      n++;
    end
    chk("cycles", x ? 1 + (io ? io_region_wait_counts[3*a[10:9] +: 3] : data_ext_wait_count) : 0,
      n);
    chk("ext", x, acc_ext);
    if (x) chk("ext_addr", e, io ? {5'h0, ext_addr[10:0]} : {2'h0, ext_addr});
    if (p) chk("refused", 1'h1, acc_fetch_refused);
    @(negedge clk);
    acc_req = 1'h0;
    @(negedge clk);
  endtask
  initial begin
    #300000;
    n_fail++;
    conclude();
  end
  initial begin
    seed = 32'h01e98fca;
    reset = 1'h1;
    byte_select_n = 1'h1;
    program_overlay_select = 2'h1;
    {strap_autoboot, strap_boot_src, strap_mem, flag_out_value, flag_dir_out, bus_granted} = '0;
    {combined_select_enables_we, combined_select_enables_wr, acc_req, acc_is_prog} = '0;
    {acc_is_io, acc_io_instr, data_overlay_select, data_ext_wait_count, acc_addr} = '0;
    io_region_wait_counts = 12'h0;
    for (k = 0; k < 4; k++) begin
      @(negedge clk);
      reset = 1'h1;
      flag_dir_out = k[0];
      {strap_mem, strap_autoboot, strap_boot_src} = cfgs[k];
      repeat (3) @(negedge clk);
      chk("oe_in_reset", 1'h0, shared_flag_pin_oe);
      reset = 1'h0;
      r = $random(seed);
      {strap_autoboot, strap_boot_src} = r[1:0];
      for (i = 0; i < 200 && run_enable !== 1'h1; i++) @(negedge clk);
      chk("run", 1'h1, run_enable);
      chk("host", cfgs[k][2], host_mode);
      chk("byte_boot", cfgs[k][1:0] == 2'h0, boot_byte_dma);
      chk("host_boot", cfgs[k][1:0] == 2'h1, boot_host_port);
      chk("words", cfgs[k][1:0] == 2'h0 ? 16'h20 : 16'h0, words_ff);
      chk("pm0", cfgs[k][1:0] == 2'h1, pm0_done_ff);
      if (cfgs[k] == 3'h2) chk("start", 1'h1, i <= 2);
      chk("enables", 4'hb, combined_select_enables);
      for (i = 0; i < 12; i++) begin
        r = $random(seed);
        data_ext_wait_count = r[2:0];
        io_region_wait_counts = r[14:3];
        data_overlay_select = r[16:15] == 2'h3 ? 2'h2 : r[16:15];
        flag_out_value = r[17];
        acc(1'h0, r[18], i == 0 ? 14'h3fff : i == 1 ? 14'h2000 : r[31:18]);
      end
      chk("pin_out", flag_out_value, shared_flag_pin_out);
      if (flag_dir_out) chk("pin_in", flag_out_value, flag_in_value);
      if (host_mode === 1'h1) acc(1'h1, 1'h0, 14'h2000);
      for (i = 0; i < 8; i++) begin
        r = i < 2 ? (i ? 32'h2c : 32'hc) : $random(seed);
        combined_select_enables_wr = r[3:0];
        combined_select_enables_we = 1'h1;
        @(negedge clk);
        combined_select_enables_we = 1'h0;
        byte_select_n = r[4];
        bus_granted = r[5];
        #1;
        chk("enables_wr", r[3:0], combined_select_enables);
        chk("combined", !(!r[4] && r[2] && !r[5]), combined_select_n);
        @(negedge clk);
      end
      byte_select_n = 1'h1;
      bus_granted = 1'h0;
      chk("host_kept", cfgs[k][2], host_mode);
    end
    conclude();
  end
endmodule
`default_nettype wire
